// ===== psr_pkg.sv
// Purpose: Shared constants and types of the power state request controller.
// Assumes: 200 MHz clock, 32-bit AXI4-Lite register bus.
// Notes: Stored sequences are constants and cannot be changed at run time.
package psr_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int HOLD_DEBOUNCE_US = 4000;
  localparam int HOLD_DB_CYCLES = HOLD_DEBOUNCE_US * CLK_MHZ;
  localparam int LONG_PRESS_MS = 1000;
  localparam int LONG_PRESS_CYCLES = LONG_PRESS_MS * CLK_MHZ * 1000;
  localparam int OFF_DELAY_UNIT_MS = 1000;
  localparam int OFF_DELAY_UNIT_CYCLES = OFF_DELAY_UNIT_MS * CLK_MHZ * 1000;
  localparam int WDOG_TIMEOUT_MS = 1000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * CLK_MHZ * 1000;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_OFF_CFG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_DEVICE_ON = 0;
  localparam int CTRL_SW_RESET = 1;
  localparam int CTRL_WDOG_EN = 2;
  localparam int CTRL_WDOG_LOCK = 3;
  localparam int CTRL_WDOG_KICK = 4;
  localparam int CFG_DELAY_LSB = 0;
  localparam int CFG_POLICY_LSB = 2;
  localparam int CFG_PD_POL = 4;
  localparam int CFG_RI_POL = 5;
  localparam int CFG_IRQ_EN_LSB = 8;
  localparam int OFFC_HW_LSB = 16;
  localparam int STAT_BUSY = 3;
  localparam int STAT_OTP_ERR = 4;
  localparam int STAT_GATE = 5;
  localparam int STAT_SRC_LSB = 8;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] OFF_CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ****************************************
  // Off request sources
  // ****************************************
  localparam int NSRC = 10;
  localparam int SRC_LONG_PRESS = 0;
  localparam int SRC_POWER_DOWN = 1;
  localparam int SRC_WDOG = 2;
  localparam int SRC_THERMAL = 3;
  localparam int SRC_RESET_IN = 4;
  localparam int SRC_SW_RESET = 5;
  localparam int SRC_DEVICE_ON = 6;
  localparam int SRC_SUPPLY_LOW = 7;
  localparam int SRC_HOLD = 8;
  localparam int SRC_CONVERTER = 9;
  localparam logic [NSRC-1:0] IMMEDIATE_SRC = 10'h1E8;
  // ****************************************
  // Policies, states and sequences
  // ****************************************
  localparam logic [1:0] POL_SKIP = 2'h0;
  localparam logic [1:0] POL_CONTINUE = 2'h1;
  localparam logic [1:0] POL_STOP_AT_IO = 2'h2;
  localparam logic [1:0] POL_HALT = 2'h3;
  typedef enum logic [2:0] {
    ST_NOSUP = 3'h4, ST_OFF = 3'h0, ST_CHECK = 3'h1, ST_RUN = 3'h3,
    ST_ACTIVE = 3'h2, ST_DELAY = 3'h6, ST_SLEEP = 3'h7, ST_HALT = 3'h5
  } psr_state_t;
  typedef enum logic [2:0] {
    SEQ_OFF_TO_ACTIVE = 3'h0, SEQ_ACTIVE_TO_OFF = 3'h1, SEQ_ACTIVE_TO_SLEEP = 3'h2,
    SEQ_SLEEP_TO_ACTIVE = 3'h3, SEQ_SLEEP_TO_OFF = 3'h4
  } psr_seq_t;
  // Entry: {last, io rail marker, resource address, value}.
  localparam int ROM_N = 13;
  localparam logic [17:0] SEQ_ROM [0:ROM_N-1] = '{
    18'h10A01, 18'h00B01, 18'h20C01,
    18'h00C00, 18'h00B00, 18'h20A00,
    18'h00B02, 18'h20C02,
    18'h00C01, 18'h20B01,
    18'h00C00, 18'h00B00, 18'h20A00};
  localparam logic [3:0] SEQ_START [0:4] = '{4'h0, 4'h3, 4'h6, 4'h8, 4'hA};
  localparam logic [15:0] FACTORY_SUM_DEFAULT = 16'h5A5A;
endpackage : psr_pkg

// ===== psr_debounce.sv
// Purpose: Level debouncer; output follows input after a stable run.
// Assumes: Input synchronous to aclk.
// Notes: Output is registered.
`timescale 1ns/100ps
module psr_debounce #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level in and out
  input wire logic level_in,
  output logic level_q
);
  logic [31:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 32'h0;
      level_q <= 1'b0;
    end else if (level_in == level_q) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
      level_q <= level_in;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule : psr_debounce

// ===== psr_ctrl.sv
// Purpose: Power state request controller with stored transition sequences.
// Assumes: All inputs synchronous to aclk; AXI4-Lite master keeps protocol.
// Notes: Sleep and wake requests arrive as plain pulses.
// Summary of operation
// RULE_01 - No sequences without supply; hardware enters off.
// RULE_02 - Only five transitions are ever sequenced.
// RULE_03 - Each transition replays fixed stored register writes.
// RULE_04 - Integrity compare at start of every power-up.
// RULE_05 - Policy: skip, continue, stop at io, halt.
// RULE_06 - Integrity error always raises memory-error flag; the code raises it under every policy except skip.
// RULE_07 - Button, enabled interrupts, debounced hold request on.
// RULE_08 - Gating conditions block every on request.
// RULE_09 - Unmasked chosen interrupts act as on requests.
// RULE_10 - Ten off sources move active or sleep off.
// RULE_11 - One switch-off delay; five sources act immediately.
// RULE_12 - Each off applies hardware or software reset level.
// RULE_13 - Per-source select: shutdown or cold restart.
// RULE_14 - Shutdown runs off sequence then stays off.
// RULE_15 - Cold restart powers up again unless gated.
// RULE_16 - Watchdog off after reset; enable and lock.
// RULE_17 - Clearing device-on bit offs only without hold.
// RULE_18 - Hold falling offs only without device-on bit.
// RULE_19 - Arbitration prioritizes concurrent requests before sequencing.
// RULE_20 - Off state leaves only always-on supply.
// RULE_21 - New request waits for running sequence end.
// RULE_22 - During delay stay put, then start off.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module psr_ctrl import psr_pkg::*; #(
  parameter int unsigned HOLD_DB = HOLD_DB_CYCLES,
  parameter int unsigned LONG_PRESS = LONG_PRESS_CYCLES,
  parameter int unsigned DELAY_UNIT = OFF_DELAY_UNIT_CYCLES,
  parameter int unsigned WDOG_TIMEOUT = WDOG_CYCLES,
  parameter logic [15:0] FACTORY_SUM = FACTORY_SUM_DEFAULT,
  parameter int IRQ_N = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Request pins and events
  input wire logic supply_valid,
  input wire logic power_button_pin_n,
  input wire logic hold_on_pin,
  input wire logic supply_high_threshold,
  input wire logic supply_low_threshold,
  input wire logic die_overtemp,
  input wire logic thermal_shutdown,
  input wire logic power_down_pin,
  input wire logic reset_in_pin,
  input wire logic converter_shutdown_event,
  input wire logic [IRQ_N-1:0] irq_events,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic [15:0] otp_live_sum,
  // Resource writes and status
  output logic seq_wr_valid,
  output logic [7:0] seq_wr_addr,
  output logic [7:0] seq_wr_data,
  output psr_state_t power_state,
  output logic always_on_only,
  output logic hardware_reset_level,
  output logic software_reset_level,
  output logic otp_error_irq
);
  // ****************************************
  // Register bus
  // ****************************************
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, wmask;
  logic wr_fire;
  logic device_on_q, wdog_en_q, wdog_lock_q, software_reset_bit_q, kick_q;
  logic [31:0] config_q, off_cfg_q, status_w;
  logic otp_err_q;
  psr_state_t state_q;
  psr_seq_t seq_q;
  logic [3:0] idx_q, src_q;
  logic gate;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (!aw_got_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata & wmask;
      end else if (!w_got_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > REG_STATUS || awaddr_q[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign status_w = {20'h0, src_q, 2'h0, gate, otp_err_q, (state_q == ST_RUN), state_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {28'h0, wdog_lock_q, wdog_en_q, 1'b0, device_on_q};
        REG_CONFIG: s_axi_rdata <= config_q;
        REG_OFF_CFG: s_axi_rdata <= off_cfg_q;
        REG_STATUS: s_axi_rdata <= status_w;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic wr_ctrl, off_done, hw_done;
  assign wr_ctrl = wr_fire && awaddr_q == REG_CTRL && wmask[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_on_q <= 1'b0;
      wdog_en_q <= 1'b0;
      wdog_lock_q <= 1'b0;
      config_q <= CONFIG_RESET;
      off_cfg_q <= OFF_CFG_RESET;
    end else begin
      if (off_done) begin
        device_on_q <= 1'b0;
      end else if (wr_ctrl) begin
        device_on_q <= wdata_q[CTRL_DEVICE_ON];
      end
      // Lock holds off later watchdog enable and lock writes until a hardware level reset. [RULE_16]
      if (hw_done) begin
        wdog_en_q <= 1'b0;
        wdog_lock_q <= 1'b0;
        config_q <= CONFIG_RESET;
        off_cfg_q <= OFF_CFG_RESET;
      end else begin
        if (wr_ctrl && !wdog_lock_q) begin
          wdog_en_q <= wdata_q[CTRL_WDOG_EN];
          wdog_lock_q <= wdata_q[CTRL_WDOG_LOCK];
        end
        if (wr_fire && awaddr_q == REG_CONFIG) begin
          config_q <= (config_q & ~wmask) | wdata_q;
        end
        if (wr_fire && awaddr_q == REG_OFF_CFG) begin
          off_cfg_q <= (off_cfg_q & ~wmask) | wdata_q;
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      software_reset_bit_q <= 1'b0;
      kick_q <= 1'b0;
    end else begin
      software_reset_bit_q <= wr_ctrl && wdata_q[CTRL_SW_RESET];
      kick_q <= wr_ctrl && wdata_q[CTRL_WDOG_KICK];
    end
  end

  // ****************************************
  // Request sources
  // ****************************************
  logic hold_db, press_db, hold_prev_q, dev_prev_q, pd_act, ri_act;
  logic wdog_to;
  logic [31:0] wdog_cnt_q, dly_cnt_q, dly_target;
  logic [IRQ_N-1:0] irq_prev_q, irq_on;
  logic [NSRC-1:0] pend_q, off_lvl, ev;
  logic on_req, take_off, imm_off;
  logic [3:0] pick;

  psr_debounce #(.CYCLES(HOLD_DB)) u_hold (
    .aclk(aclk), .aresetn(aresetn), .level_in(hold_on_pin), .level_q(hold_db));
  psr_debounce #(.CYCLES(LONG_PRESS)) u_press (
    .aclk(aclk), .aresetn(aresetn), .level_in(!power_button_pin_n), .level_q(press_db));

  assign pd_act = config_q[CFG_PD_POL] ? power_down_pin : !power_down_pin;
  assign ri_act = config_q[CFG_RI_POL] ? reset_in_pin : !reset_in_pin;
  assign gate = !supply_high_threshold || die_overtemp || pd_act || ri_act; // [RULE_08]
  assign irq_on = irq_events & ~irq_prev_q & config_q[CFG_IRQ_EN_LSB +: IRQ_N]; // [RULE_09]
  assign on_req = !power_button_pin_n || hold_db || (|irq_on); // [RULE_07]
  assign wdog_to = wdog_en_q && wdog_cnt_q >= 32'(WDOG_TIMEOUT - 1);

  // Edge-born requests are held pending so none is lost while a sequence runs.
  always_comb begin
    ev = '0;
    ev[SRC_WDOG] = wdog_to;
    ev[SRC_SW_RESET] = software_reset_bit_q;
    ev[SRC_DEVICE_ON] = dev_prev_q && !device_on_q && !hold_db; // [RULE_17]
    ev[SRC_HOLD] = hold_prev_q && !hold_db && !device_on_q; // [RULE_18]
    ev[SRC_CONVERTER] = converter_shutdown_event;
    off_lvl = pend_q | ev;
    off_lvl[SRC_LONG_PRESS] = press_db;
    off_lvl[SRC_POWER_DOWN] = pd_act;
    off_lvl[SRC_THERMAL] = thermal_shutdown;
    off_lvl[SRC_RESET_IN] = ri_act;
    off_lvl[SRC_SUPPLY_LOW] = supply_low_threshold; // [RULE_10]
  end

  // Immediate sources win, then the lowest numbered source. [RULE_19]
  always_comb begin
    pick = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (off_lvl[i] && !IMMEDIATE_SRC[i]) begin
        pick = 4'(i);
      end
    end
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (off_lvl[i] && IMMEDIATE_SRC[i]) begin
        pick = 4'(i);
      end
    end
  end
  assign imm_off = |(off_lvl & IMMEDIATE_SRC);
  assign take_off = (state_q == ST_ACTIVE || state_q == ST_SLEEP || state_q == ST_HALT)
                    && (|off_lvl);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= '0;
      hold_prev_q <= 1'b0;
      dev_prev_q <= 1'b0;
      irq_prev_q <= '0;
      wdog_cnt_q <= 32'h0;
    end else begin
      hold_prev_q <= hold_db;
      dev_prev_q <= device_on_q;
      irq_prev_q <= irq_events;
      pend_q <= (state_q == ST_OFF) ? '0 : (pend_q | ev);
      if (!wdog_en_q || kick_q || wdog_to) begin
        wdog_cnt_q <= 32'h0;
      end else begin
        wdog_cnt_q <= wdog_cnt_q + 32'h1;
      end
    end
  end

  // ****************************************
  // Power state machine and sequencer
  // ****************************************
  logic [17:0] rom_w;
  logic restart_q, hw_lvl_q, from_sleep_q, stop_io_q, check_err;
  logic [1:0] policy;
  assign rom_w = SEQ_ROM[idx_q];
  assign policy = config_q[CFG_POLICY_LSB +: 2];
  assign check_err = otp_live_sum != FACTORY_SUM; // [RULE_04]
  assign off_done = state_q == ST_RUN && rom_w[17]
                    && (seq_q == SEQ_ACTIVE_TO_OFF || seq_q == SEQ_SLEEP_TO_OFF);
  assign hw_done = off_done && hw_lvl_q;
  always_comb begin
    unique case (config_q[CFG_DELAY_LSB +: 2])
      2'h0: dly_target = 32'h0;
      2'h1: dly_target = 32'(DELAY_UNIT);
      2'h2: dly_target = 32'(DELAY_UNIT * 2);
      2'h3: dly_target = 32'(DELAY_UNIT * 4);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_NOSUP;
      seq_q <= SEQ_OFF_TO_ACTIVE;
      idx_q <= 4'h0;
      src_q <= 4'h0;
      restart_q <= 1'b0;
      hw_lvl_q <= 1'b0;
      from_sleep_q <= 1'b0;
      stop_io_q <= 1'b0;
      dly_cnt_q <= 32'h0;
    end else if (!supply_valid) begin
      state_q <= ST_NOSUP; // [RULE_01]
    end else begin
      unique case (state_q)
        ST_NOSUP: state_q <= ST_OFF; // [RULE_01]
        ST_OFF: if (on_req && !gate) state_q <= ST_CHECK; // [RULE_07]
        ST_CHECK: begin
          stop_io_q <= policy == POL_STOP_AT_IO && check_err;
          seq_q <= SEQ_OFF_TO_ACTIVE;
          idx_q <= SEQ_START[SEQ_OFF_TO_ACTIVE];
          state_q <= (policy == POL_HALT && check_err) ? ST_OFF : ST_RUN; // [RULE_05]
        end
        ST_RUN: begin
          // Nothing new starts before the last write of this series. [RULE_21]
          idx_q <= idx_q + 4'h1; // [RULE_03]
          if (seq_q == SEQ_OFF_TO_ACTIVE && stop_io_q && rom_w[16]) begin
            state_q <= ST_HALT; // [RULE_05]
          end else if (rom_w[17]) begin
            unique case (seq_q)
              SEQ_OFF_TO_ACTIVE, SEQ_SLEEP_TO_ACTIVE: state_q <= ST_ACTIVE; // [RULE_02]
              SEQ_ACTIVE_TO_SLEEP: state_q <= ST_SLEEP;
              default: state_q <= (restart_q && !gate) ? ST_CHECK : ST_OFF; // [RULE_14] [RULE_15]
            endcase
          end
        end
        ST_ACTIVE, ST_SLEEP, ST_HALT, ST_DELAY: begin
          if (take_off && state_q != ST_DELAY) begin
            src_q <= pick;
            restart_q <= off_cfg_q[pick] && pick != 4'(SRC_DEVICE_ON)
                         && pick != 4'(SRC_HOLD); // [RULE_13]
            hw_lvl_q <= off_cfg_q[OFFC_HW_LSB + 32'(pick)] && pick != 4'(SRC_DEVICE_ON)
                        && pick != 4'(SRC_HOLD); // [RULE_12]
            from_sleep_q <= state_q == ST_SLEEP;
            dly_cnt_q <= 32'h0;
            state_q <= ST_DELAY; // [RULE_10]
          end else if (state_q == ST_DELAY) begin
            // The present state is kept while counting. [RULE_22]
            if (IMMEDIATE_SRC[src_q] || dly_cnt_q >= dly_target || imm_off) begin
              seq_q <= from_sleep_q ? SEQ_SLEEP_TO_OFF : SEQ_ACTIVE_TO_OFF; // [RULE_11]
              idx_q <= from_sleep_q ? SEQ_START[SEQ_SLEEP_TO_OFF]
                                    : SEQ_START[SEQ_ACTIVE_TO_OFF];
              state_q <= ST_RUN;
            end else begin
              dly_cnt_q <= dly_cnt_q + 32'h1;
            end
          end else if (state_q == ST_ACTIVE && sleep_req) begin
            seq_q <= SEQ_ACTIVE_TO_SLEEP;
            idx_q <= SEQ_START[SEQ_ACTIVE_TO_SLEEP];
            state_q <= ST_RUN;
          end else if (state_q == ST_SLEEP && wake_req) begin
            seq_q <= SEQ_SLEEP_TO_ACTIVE;
            idx_q <= SEQ_START[SEQ_SLEEP_TO_ACTIVE];
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_wr_valid <= 1'b0;
      seq_wr_addr <= 8'h00;
      seq_wr_data <= 8'h00;
      power_state <= ST_NOSUP;
      always_on_only <= 1'b1;
      hardware_reset_level <= 1'b0;
      software_reset_level <= 1'b0;
      otp_err_q <= 1'b0;
    end else begin
      seq_wr_valid <= state_q == ST_RUN && supply_valid;
      seq_wr_addr <= rom_w[15:8];
      seq_wr_data <= rom_w[7:0];
      power_state <= state_q;
      always_on_only <= state_q == ST_OFF || state_q == ST_NOSUP; // [RULE_20]
      hardware_reset_level <= off_done && hw_lvl_q && supply_valid; // [RULE_12]
      software_reset_level <= off_done && !hw_lvl_q && supply_valid;
      // A new error wins over a clear in the same cycle. [RULE_06]
      if (state_q == ST_CHECK && supply_valid && policy != POL_SKIP && check_err) begin
        otp_err_q <= 1'b1;
      end else if (wr_fire && awaddr_q == REG_STATUS && wdata_q[STAT_OTP_ERR]) begin
        otp_err_q <= 1'b0;
      end
    end
  end
  assign otp_error_irq = otp_err_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_off_end;
    state_q == ST_RUN && off_done && !restart_q && supply_valid;
  endsequence
  sequence s_off_rest;
    state_q == ST_OFF [*2];
  endsequence
  nosup_hold_a: assert property (!supply_valid |=> state_q == ST_NOSUP ##1 !seq_wr_valid) // [RULE_01]
    else $error("sequence ran without supply");
  active_from_a: assert property ($rose(state_q == ST_ACTIVE) |->
    $past(seq_q) == SEQ_OFF_TO_ACTIVE || $past(seq_q) == SEQ_SLEEP_TO_ACTIVE) // [RULE_02]
    else $error("active reached by illegal transition");
  rom_replay_a: assert property (state_q == ST_RUN && supply_valid |=>
    seq_wr_valid && {seq_wr_addr, seq_wr_data} == $past(rom_w[15:0])) // [RULE_03]
    else $error("resource write differs from stored entry");
  check_first_a: assert property ($rose(state_q == ST_RUN && seq_q == SEQ_OFF_TO_ACTIVE) |->
    $past(state_q) == ST_CHECK) // [RULE_04]
    else $error("power-up started without integrity check");
  halt_policy_a: assert property (state_q == ST_CHECK && supply_valid && policy == POL_HALT
    && check_err |=> state_q == ST_OFF) // [RULE_05]
    else $error("halt policy did not stop power-up");
  err_flag_a: assert property (state_q == ST_CHECK && supply_valid && policy != POL_SKIP
    && check_err |=> otp_error_irq [*2]) // [RULE_06]
    else $error("memory error flag not raised");
  gate_block_a: assert property (state_q == ST_OFF && gate && supply_valid |=>
    state_q != ST_CHECK) // [RULE_08]
    else $error("on request passed a gating condition");
  shutdown_stay_a: assert property (s_off_end ##1 supply_valid && !on_req |-> s_off_rest) // [RULE_14]
    else $error("shutdown did not remain off");
  delay_hold_a: assert property (state_q == ST_DELAY && supply_valid && !imm_off
    && !IMMEDIATE_SRC[src_q] && dly_cnt_q < dly_target |=> state_q == ST_DELAY) // [RULE_22]
    else $error("left delay early");
  wdog_reset_a: assert property ($rose(aresetn) |-> !wdog_en_q ##1 !wdog_en_q) // [RULE_16]
    else $error("watchdog enabled after reset");
  device_on_bit_hold_a: assert property (ev[SRC_DEVICE_ON] |-> !hold_db) // [RULE_17]
    else $error("device-on cleared off while held");
endmodule : psr_ctrl

// ===== psr_host.sv
// Purpose: Host side pin model for the power state request controller.
// Assumes: Pins change just after aclk rising edges.
// Notes: A board pull-up keeps the button released between presses.
`timescale 1ns/100ps
module psr_host (
  // Clock
  input wire logic aclk,
  // System pins
  output logic power_button_pin_n,
  output logic hold_on_pin
);
  initial begin
    power_button_pin_n = 1'b1;
    hold_on_pin = 1'b0;
  end
  // The button is level sensitive, so it is held low for n cycles.
  task automatic press(input int n);
    @(posedge aclk);
    power_button_pin_n <= 1'b0;
    repeat (n) @(posedge aclk);
    power_button_pin_n <= 1'b1;
  endtask : press
endmodule : psr_host

// ===== test_power_state_request_controller.sv
// Purpose: Self-checking bench of the power state request controller.
// Assumes: Shortened counts; AXI4-Lite master waits for every answer.
// Notes: Sequence writes are counted to see which stored series ran.
`timescale 1ns/100ps
module test_power_state_request_controller import psr_pkg::*;;
  logic aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, supply_valid, supply_high_threshold, supply_low_threshold;
  logic die_overtemp, thermal_shutdown, power_down_pin, reset_in_pin, sleep_req, wake_req;
  logic converter_shutdown_event, power_button_pin_n, hold_on_pin;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic seq_wr_valid, always_on_only, hardware_reset_level, software_reset_level, otp_error_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, seq_wr_addr, seq_wr_data, irq_events;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] otp_live_sum;
  psr_state_t power_state;
  int num_errors = 0, checks = 0, nwr = 0;
  always #2.5 aclk = ~aclk;
  psr_ctrl #(.HOLD_DB(4), .LONG_PRESS(8), .DELAY_UNIT(10), .WDOG_TIMEOUT(50)) dut_u (.*);
  psr_host host_u (.*);
  always @(posedge aclk) if (seq_wr_valid === 1'b1) nwr <= nwr + 1;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_awvalid | s_axi_wvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wst(input psr_state_t s);
    for (int i = 0; i < 300 && power_state !== s; i++) @(posedge aclk);
  endtask : wst
  task automatic close_out;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #30000;
    num_errors++;
    close_out();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {supply_low_threshold, die_overtemp, thermal_shutdown, sleep_req, wake_req} = '0;
    {supply_valid, supply_high_threshold, power_down_pin, reset_in_pin} = 4'hF;
    {converter_shutdown_event, irq_events, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0; s_axi_wstrb = 4'hF; otp_live_sum = FACTORY_SUM_DEFAULT;
    repeat (4) @(posedge aclk);
    chk("state in reset", power_state, ST_NOSUP);
    aresetn <= 1'b1;
    wst(ST_OFF);
    chk("always on only", always_on_only, 1'b1);
    supply_high_threshold <= 1'b0;
    host_u.press(6);
    repeat (20) @(posedge aclk);
    chk("gated on", power_state, ST_OFF);
    supply_high_threshold <= 1'b1;
    host_u.press(6);
    wst(ST_ACTIVE);
    chk("power up writes", nwr, 3);
    wr(REG_CTRL, 32'h0000_0002);
    chk("write resp", r, AXI_OKAY);
    wst(ST_OFF);
    chk("shutdown writes", nwr, 6);
    rd(8'h10);
    chk("unmapped resp", r, AXI_SLVERR);
    rd(REG_STATUS);
    chk("status state", d[2:0], ST_OFF);
    otp_live_sum <= 16'h0000;
    wr(REG_CONFIG, 32'h0000_000C);
    host_u.press(6);
    repeat (30) @(posedge aclk);
    chk("memory error", otp_error_irq, 1'b1);
    chk("halt no writes", nwr, 6);
    otp_live_sum <= FACTORY_SUM_DEFAULT;
    die_overtemp <= 1'b1;
    wr(REG_CONFIG, 32'h0000_0100);
    host_u.press(6);
    repeat (10) @(posedge aclk);
    chk("hot die gated", power_state, ST_OFF);
    die_overtemp <= 1'b0;
    host_u.press(6);
    wst(ST_ACTIVE);
    chk("second power up", nwr, 9);
    @(posedge aclk) sleep_req <= 1'b1;
    @(posedge aclk) sleep_req <= 1'b0;
    wst(ST_SLEEP);
    chk("sleep writes", nwr, 11);
    @(posedge aclk) wake_req <= 1'b1;
    @(posedge aclk) wake_req <= 1'b0;
    wst(ST_ACTIVE);
    chk("wake writes", nwr, 13);
    @(posedge aclk) converter_shutdown_event <= 1'b1;
    @(posedge aclk) converter_shutdown_event <= 1'b0;
    wst(ST_OFF);
    chk("converter off writes", nwr, 16);
    @(posedge aclk) irq_events <= 8'h01;
    @(posedge aclk) irq_events <= 8'h00;
    wst(ST_ACTIVE);
    chk("irq power up", nwr, 19);
    @(posedge aclk) thermal_shutdown <= 1'b1;
    @(posedge aclk) thermal_shutdown <= 1'b0;
    wst(ST_OFF);
    chk("thermal off writes", nwr, 22);
    supply_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("no supply", power_state, ST_NOSUP);
    supply_valid <= 1'b1;
    wst(ST_OFF);
    chk("back to off", power_state, ST_OFF);
    close_out();
  end
endmodule : test_power_state_request_controller
